// ===== common/cocs_consts.svh
// Purpose: shared constants for the clock output control block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef COCS_CONSTS_SVH
`define COCS_CONSTS_SVH
`define COCS_SLV_ADDR     7'h69
`define COCS_CMD_CODE     8'h00
`define COCS_CNT_MIN      8'h01
`define COCS_CNT_MAX      8'h20
`define COCS_NBYTES       5
`define COCS_BYTE0_RST    8'h00
`define COCS_BYTE1_RST    8'h07
`define COCS_BYTE2_RST    8'h7F
`define COCS_BYTE3_RST    8'hC7
`define COCS_BYTE4_RST    8'h38
`define COCS_B1_CPU_OE    2
`define COCS_B1_CPU_FREE  5
`define COCS_B3_PCIF_OE   2
`define COCS_B3_PCIF_STP  5
`define COCS_B3_USB_OE    6
`define COCS_B3_DOT_OE    7
`define COCS_B4_V66_5_OE  3
`define COCS_B4_V66_1_OE  4
`define COCS_B4_V66_0_OE  5
`define COCS_B0_VCH_SEL   5
`define COCS_SCL_DIV      8'h20
`endif

// ===== common/cocs_pkg.sv
// Purpose: types for the clock output control block
// Assumes: nothing
// Notes:   constants live in cocs_consts.svh
package cocs_pkg;
  typedef enum logic [4:0] {
    COCS_M_INT    = 5'h01,
    COCS_M_BUF    = 5'h02,
    COCS_M_TRI    = 5'h04,
    COCS_M_TEST   = 5'h08,
    COCS_M_RSVD   = 5'h10
  } cocs_mode_t;
  typedef enum logic [4:0] {
    COCS_S_IDLE   = 5'h01,
    COCS_S_BITS   = 5'h02,
    COCS_S_ACK    = 5'h04,
    COCS_S_IGNORE = 5'h08,
    COCS_S_STOP   = 5'h10
  } cocs_sl_state_t;
endpackage

// ===== common/cocs_smbus_if.sv
// Purpose: two-wire link between host and clock device
// Assumes: open drain, pulled high when nobody drives
// Notes:   resolved level computed from the enables
`timescale 1ns/1ps
interface cocs_smbus_if;
  logic smb_clk;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output smb_clk, output host_sda_oe, input sda);
  modport dev  (input smb_clk, output dev_sda_oe, input sda);
endinterface

// ===== logic/cocs_device.sv
// Purpose: clock synthesizer control: select decode, output gating, smbus slave
// Assumes: smb_clk is the link clock domain, core_clk_i runs the output control
// Notes:   slave logic runs on smb_clk; start/stop sampled with data on that clock
// Operation
// - only block writes change settings
// - bytes ascending from byte zero, msb first
// - stop after any whole byte keeps it
// - host never addresses a byte offset
// - answer only address 11010010
// - direction bit zero means write
// - host sends command zero then count
// - count equals following data bytes
// - count from one to 32
// - data applied after count acknowledged
// - config loads defaults at power up
// - config bits enable outputs individually
// - test mode references external test clock
// - margin and test reuse top divider; here only test mode forces 2'h2
// - sample selects while power good low
// - power down and stops active low
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "cocs_consts.svh"
module cocs_device
  import cocs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  cocs_smbus_if.dev       smb,
  input  wire logic       mode_select_mid_i,
  input  wire logic       mode_select_tristate_i,
  input  wire logic       freq_select_hi_i,
  input  wire logic       freq_select_lo_i,
  input  wire logic       swing_multiplier_select_i,
  input  wire logic       power_good_strobe_n_i,
  input  wire logic       power_down_n_i,
  input  wire logic       cpu_stop_n_i,
  input  wire logic       pci_stop_n_i,
  output logic            osc_run_o,
  output logic            use_test_clock_o,
  output logic            outputs_hiz_o,
  output logic [1:0]      cpu_freq_sel_o,
  output logic            buffered_66_mode_o,
  output logic            swing_mult_o,
  output logic            slow_vco_o,
  output logic [2:0]      cpu_en_o,
  output logic [6:0]      pci_en_o,
  output logic [2:0]      pci_free_en_o,
  output logic [2:0]      internal_66_en_o,
  output logic            usb_en_o,
  output logic            display_48m_en_o,
  output logic            video_hub_sel_o,
  output logic            spread_en_o
);
  ////////////////////////////////////////////////////////////////////////////
  // link domain: smbus slave
  logic                       sda_d_ff;
  cocs_sl_state_t             st_ff;
  logic [3:0]                 bit_ff;
  logic [7:0]                 sh_ff;
  logic [7:0]                 nb;
  logic [7:0]                 cnt_ff;
  logic [5:0]                 idx_ff;
  logic                       sda_oe_ff;
  logic [7:0]                 cfg_ff [`COCS_NBYTES];
  logic                       upd_tgl_ff;
  logic                       start_c;
  logic                       byte_ok;

  // sda is launched on the falling link edge, so it is already settled in
  // this domain at the rise; a synchroniser would make the ack bits late
  always_ff @(posedge smb.smb_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_d_ff <= 1'h1;
    end else begin
      sda_d_ff <= smb.sda;
    end
  end
  assign nb      = {sh_ff[6:0], smb.sda};
  assign start_c = sda_d_ff & ~smb.sda & (st_ff == COCS_S_IDLE);

  always_comb begin
    byte_ok = 1'h1;
    if (idx_ff == 6'h00 && nb != {`COCS_SLV_ADDR, 1'h0}) begin
      byte_ok = 1'h0;
    end else if (idx_ff == 6'h01 && nb != `COCS_CMD_CODE) begin
      byte_ok = 1'h0;
    end else if (idx_ff == 6'h02 && (nb < `COCS_CNT_MIN || nb > `COCS_CNT_MAX)) begin
      byte_ok = 1'h0;
    end
  end

  // byte sequencing: 0 address, 1 command, 2 count, then data
  always_ff @(posedge smb.smb_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff      <= COCS_S_IDLE;
      bit_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      cnt_ff     <= 8'h00;
      idx_ff     <= 6'h00;
      sda_oe_ff  <= 1'h0;
      upd_tgl_ff <= 1'h0;
      cfg_ff[0]  <= `COCS_BYTE0_RST;
      cfg_ff[1]  <= `COCS_BYTE1_RST;
      cfg_ff[2]  <= `COCS_BYTE2_RST;
      cfg_ff[3]  <= `COCS_BYTE3_RST;
      cfg_ff[4]  <= `COCS_BYTE4_RST;
    end else begin
      case (st_ff)
        COCS_S_IDLE: begin
          sda_oe_ff <= 1'h0;
          if (start_c) begin
            st_ff  <= COCS_S_BITS;
            bit_ff <= 4'h0;
            idx_ff <= 6'h00;
          end
        end
        COCS_S_BITS: begin
          sda_oe_ff <= 1'h0;
          sh_ff     <= nb;
          bit_ff    <= bit_ff + 4'h1;
          if (bit_ff == 4'h7) begin
            // ack decided on the last bit so it stands at the next rise
            sda_oe_ff <= byte_ok;
            st_ff     <= byte_ok ? COCS_S_ACK : COCS_S_IGNORE;
          end
        end
        COCS_S_ACK: begin
          sda_oe_ff <= 1'h0;
          bit_ff    <= 4'h0;
          idx_ff    <= idx_ff + 6'h01;
          st_ff     <= COCS_S_BITS;
          if (idx_ff == 6'h02) begin
            cnt_ff <= sh_ff;
          end
          if (idx_ff >= 6'h03 && idx_ff < 6'(3 + `COCS_NBYTES)) begin
            cfg_ff[3'(idx_ff - 6'h03)] <= sh_ff;
            upd_tgl_ff                 <= ~upd_tgl_ff;
          end
          if (idx_ff >= 6'h03 && idx_ff == 6'(cnt_ff + 8'h02)) begin
            st_ff <= COCS_S_IDLE;
          end
        end
        COCS_S_IGNORE: begin
          sda_oe_ff <= 1'h0;
          if (smb.sda & ~sda_d_ff) begin
            st_ff <= COCS_S_IDLE;
          end
        end
        default: begin
          st_ff <= COCS_S_IDLE;
        end
      endcase
    end
  end
  assign smb.dev_sda_oe = sda_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // core domain: crossing of configuration by toggle handshake
  logic [2:0]  tgl_sync_ff;
  logic [7:0]  cfg_core_ff [`COCS_NBYTES];
  logic [1:0]  pg_sync_ff;
  logic [1:0]  pd_sync_ff;
  logic [1:0]  cs_sync_ff;
  logic [1:0]  ps_sync_ff;
  logic        sampled_ff;
  cocs_mode_t  mode_ff;
  logic [1:0]  fsel_ff;
  logic        mult_ff;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_sync_ff <= 3'h0;
      pg_sync_ff  <= 2'h3;
      pd_sync_ff  <= 2'h0;
      cs_sync_ff  <= 2'h3;
      ps_sync_ff  <= 2'h3;
    end else if (clk_en_i) begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], upd_tgl_ff};
      pg_sync_ff  <= {pg_sync_ff[0], power_good_strobe_n_i};
      pd_sync_ff  <= {pd_sync_ff[0], power_down_n_i};
      cs_sync_ff  <= {cs_sync_ff[0], cpu_stop_n_i};
      ps_sync_ff  <= {ps_sync_ff[0], pci_stop_n_i};
    end
  end

  // config words stable for many smb cycles after the toggle, safe to copy
  genvar g;
  generate
    for (g = 0; g < `COCS_NBYTES; g++) begin : g_cfg
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cfg_core_ff[g] <= (g == 0) ? `COCS_BYTE0_RST : (g == 1) ? `COCS_BYTE1_RST :
                            (g == 2) ? `COCS_BYTE2_RST : (g == 3) ? `COCS_BYTE3_RST :
                            `COCS_BYTE4_RST;
        end else if (clk_en_i && (tgl_sync_ff[2] != tgl_sync_ff[1])) begin
          cfg_core_ff[g] <= cfg_ff[g];
        end
      end
    end
  endgenerate

  // straps caught once while power good is low, then held
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sampled_ff <= 1'h0;
      mode_ff    <= COCS_M_INT;
      fsel_ff    <= 2'h0;
      mult_ff    <= 1'h0;
    end else if (clk_en_i && !sampled_ff && !pg_sync_ff[1]) begin
      sampled_ff <= 1'h1;
      fsel_ff    <= {freq_select_hi_i, freq_select_lo_i};
      mult_ff    <= swing_multiplier_select_i;
      if (mode_select_mid_i) begin
        case ({freq_select_hi_i, freq_select_lo_i})
          2'h0:    mode_ff <= COCS_M_TRI;
          2'h1:    mode_ff <= COCS_M_TEST;
          default: mode_ff <= COCS_M_RSVD;
        endcase
      end else if (mode_select_tristate_i) begin
        mode_ff <= COCS_M_BUF;
      end else begin
        mode_ff <= COCS_M_INT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output gating
  logic pd_on;
  logic cs_on;
  logic ps_on;
  logic live;
  assign pd_on = ~pd_sync_ff[1];
  assign cs_on = ~cs_sync_ff[1];
  assign ps_on = ~ps_sync_ff[1];
  assign live  = ~pd_on & (mode_ff != COCS_M_TRI) & (mode_ff != COCS_M_RSVD);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_run_o          <= 1'h0;
      use_test_clock_o   <= 1'h0;
      outputs_hiz_o      <= 1'h0;
      cpu_freq_sel_o     <= 2'h0;
      buffered_66_mode_o <= 1'h0;
      swing_mult_o       <= 1'h0;
      slow_vco_o         <= 1'h0;
      cpu_en_o           <= 3'h0;
      pci_en_o           <= 7'h00;
      pci_free_en_o      <= 3'h0;
      internal_66_en_o   <= 3'h0;
      usb_en_o           <= 1'h0;
      display_48m_en_o   <= 1'h0;
      video_hub_sel_o    <= 1'h0;
      spread_en_o        <= 1'h0;
    end else if (clk_en_i) begin
      osc_run_o          <= ~pd_on;
      use_test_clock_o   <= (mode_ff == COCS_M_TEST);
      outputs_hiz_o      <= (mode_ff == COCS_M_TRI) | (mode_ff == COCS_M_RSVD);
      // only test mode forces the top-rate divider (2'h2), vco slowed instead
      cpu_freq_sel_o     <= (mode_ff == COCS_M_TEST) ? 2'h2 : fsel_ff;
      slow_vco_o         <= (mode_ff == COCS_M_TEST);
      buffered_66_mode_o <= (mode_ff == COCS_M_BUF);
      swing_mult_o       <= mult_ff;
      cpu_en_o           <= {3{live}} & cfg_core_ff[1][`COCS_B1_CPU_OE -: 3] &
                            ({3{~cs_on}} | cfg_core_ff[1][`COCS_B1_CPU_FREE -: 3]);
      pci_en_o           <= {7{live & ~ps_on}} & cfg_core_ff[2][6:0];
      pci_free_en_o      <= {3{live}} & cfg_core_ff[3][`COCS_B3_PCIF_OE -: 3] &
                            ~({3{ps_on}} & cfg_core_ff[3][`COCS_B3_PCIF_STP -: 3]);
      internal_66_en_o   <= {3{live}} & {cfg_core_ff[4][`COCS_B4_V66_0_OE],
                            cfg_core_ff[4][`COCS_B4_V66_1_OE], cfg_core_ff[4][`COCS_B4_V66_5_OE]};
      usb_en_o           <= live & cfg_core_ff[3][`COCS_B3_USB_OE];
      display_48m_en_o   <= live & cfg_core_ff[3][`COCS_B3_DOT_OE];
      video_hub_sel_o    <= cfg_core_ff[0][`COCS_B0_VCH_SEL];
      spread_en_o        <= cfg_core_ff[0][7];
    end
  end
endmodule

// ===== logic/cocs_host.sv
// Purpose: smbus host end: sends one block write of configuration bytes
// Assumes: software loads data through the plain register port
// Notes:   link clock made by dividing core_clk_i; one data bit per link clock
`timescale 1ns/1ps
`include "cocs_consts.svh"
module cocs_host
  import cocs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       clk_en_i,
  cocs_smbus_if.host      smb,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o
);
  // regs 0..4 data bytes, 5 count (write starts), 6 status bit0 busy
  logic [7:0]  dat_ff [`COCS_NBYTES];
  logic [7:0]  cnt_ff;
  logic        busy_ff;
  logic [7:0]  div_ff;
  logic        sclk_ff;
  logic [5:0]  byte_ff;
  logic [3:0]  bit_ff;
  logic        oe_ff;
  logic [7:0]  cur;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_ff  <= 8'h00;
      sclk_ff <= 1'h0;
    end else if (clk_en_i) begin
      div_ff <= (div_ff == `COCS_SCL_DIV) ? 8'h00 : div_ff + 8'h01;
      if (div_ff == `COCS_SCL_DIV) begin
        sclk_ff <= ~sclk_ff;
      end
    end
  end
  assign smb.smb_clk = sclk_ff;

  // frame: start low bit, then address, command, count, data, 9 bits each
  always_comb begin
    case (byte_ff)
      6'h00:   cur = {`COCS_SLV_ADDR, 1'h0};
      6'h01:   cur = `COCS_CMD_CODE;
      6'h02:   cur = cnt_ff;
      default: cur = (byte_ff < 6'(3 + `COCS_NBYTES)) ? dat_ff[3'(byte_ff - 6'h03)] : 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_ff <= 1'h0;
      byte_ff <= 6'h00;
      bit_ff  <= 4'h0;
      oe_ff   <= 1'h0;
      cnt_ff  <= `COCS_CNT_MIN;
      for (int i = 0; i < `COCS_NBYTES; i++) begin
        dat_ff[i] <= 8'h00;
      end
    end else if (clk_en_i) begin
      if (wr_i && !busy_ff && addr_i < 4'(`COCS_NBYTES)) begin
        dat_ff[3'(addr_i)] <= wdata_i;
      end
      if (wr_i && !busy_ff && addr_i == 4'h5 && wdata_i >= `COCS_CNT_MIN &&
          wdata_i <= 8'(`COCS_NBYTES)) begin
        cnt_ff  <= wdata_i;
        busy_ff <= 1'h1;
        byte_ff <= 6'h00;
        bit_ff  <= 4'hE;
      end
      // change data on the falling link edge so the device sees it settled
      if (busy_ff && div_ff == `COCS_SCL_DIV && sclk_ff) begin
        case (bit_ff)
          4'hE: begin
            oe_ff  <= 1'h1; // start, held one whole link period
            bit_ff <= 4'hF;
          end
          4'hF: begin
            oe_ff  <= ~cur[7];
            bit_ff <= 4'h0;
          end
          4'h7: begin
            oe_ff   <= 1'h0; // release for acknowledge
            bit_ff  <= 4'h8;
            byte_ff <= byte_ff + 6'h01;
          end
          4'h8: begin
            bit_ff <= 4'h0;
            if (byte_ff == 6'(cnt_ff + 8'h03)) begin
              busy_ff <= 1'h0;
              oe_ff   <= 1'h0;
            end else begin
              oe_ff <= ~cur[7];
            end
          end
          default: begin
            oe_ff  <= ~cur[3'(4'h6 - bit_ff)];
            bit_ff <= bit_ff + 4'h1;
          end
        endcase
      end
    end
  end
  assign smb.host_sda_oe = oe_ff;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        if (addr_i < 4'(`COCS_NBYTES)) begin
          rdata_o <= dat_ff[3'(addr_i)];
        end else if (addr_i == 4'h5) begin
          rdata_o <= cnt_ff;
        end else if (addr_i == 4'h6) begin
          rdata_o <= {7'h00, busy_ff};
        end
      end
    end
  end
endmodule

// ===== dv/cocs_properties.sv
// Purpose: wire checks on the two-wire configuration link
// Assumes: link clock domain, reset nrst_i, one sample per link clock rise
// Notes:   helper tracks bit position and byte index inside a frame
`timescale 1ns/1ps
module cocs_properties (
  input wire logic smb_clk,
  input wire logic nrst_i,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       in_frame_ff;
  logic [3:0] pos_ff;
  logic [5:0] bytes_ff;
  logic [7:0] sh_ff;
  logic [7:0] cnt_ff;
  logic       start;
  logic       ack_slot;
  logic       last_ack;
  assign start    = !in_frame_ff && !sda;
  assign ack_slot = in_frame_ff && (pos_ff == 4'h8);
  // frame ends on the ack of the data byte whose index matches the count
  assign last_ack = ack_slot && (bytes_ff > 6'h2) && (bytes_ff - 6'h2 == cnt_ff[5:0]);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge smb_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      in_frame_ff <= 1'b0;
      pos_ff      <= 4'h0;
      bytes_ff    <= 6'h0;
    end else if (start) begin
      in_frame_ff <= 1'b1;
      pos_ff      <= 4'h0;
      bytes_ff    <= 6'h0;
    end else if (ack_slot) begin
      pos_ff   <= 4'h0;
      bytes_ff <= bytes_ff + 6'h1;
      if (last_ack) begin
        in_frame_ff <= 1'b0;
      end
    end else if (in_frame_ff) begin
      pos_ff <= pos_ff + 4'h1;
    end
  end
  always_ff @(posedge smb_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_ff  <= 8'h00;
      cnt_ff <= 8'h00;
    end else if (in_frame_ff && !ack_slot) begin
      sh_ff <= {sh_ff[6:0], sda};
    end else if (ack_slot && bytes_ff == 6'h2) begin
      cnt_ff <= sh_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge smb_clk); endclocking
  default disable iff (!nrst_i);
  sequence addr_s;
    sda ##1 sda ##1 !sda ##1 sda ##1 !sda ##1 !sda ##1 sda ##1 !sda;
  endsequence
  sequence ack_s;
    dev_sda_oe;
  endsequence
  sequence cmd_s;
    !sda [*8];
  endsequence
  AST_ADDR_BYTE: assert property (start |=> addr_s)
    else $error("address byte on the wire is not the write address");
  AST_CMD_BYTE: assert property (start |=> addr_s ##1 ack_s ##1 cmd_s ##1 ack_s)
    else $error("command byte missing or not zero");
  AST_ACK_ONLY_SLOT: assert property (dev_sda_oe |-> ack_slot)
    else $error("device drove data outside an ack slot");
  AST_ACK_EACH_BYTE: assert property (ack_slot |-> dev_sda_oe)
    else $error("device left an ack slot released");
  AST_HOST_RELEASES: assert property (ack_slot |-> !host_sda_oe)
    else $error("host drove data in an ack slot");
  AST_COUNT_RANGE: assert property ((ack_slot && bytes_ff == 6'h2) |-> (sh_ff >= 8'h01 && sh_ff <= 8'h20))
    else $error("byte count outside one to 32");
  AST_QUIET_AFTER: assert property (last_ack |=> sda [*2])
    else $error("more data after the counted bytes");
  AST_ACK_PULSE: assert property ($rose(dev_sda_oe) |=> !dev_sda_oe)
    else $error("ack held longer than one bit");
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench, host and device joined over the link
// Assumes: host makes the link clock; selects latched on power good low
// Notes:   each scenario resets or reuses state as stated in its task
`timescale 1ns/1ps
module tb;
  import cocs_pkg::*;
  logic core_clk_i = 0, nrst_i = 0, wr = 0, rd = 0, mid = 0, tri_s = 0, fhi = 0, flo = 0;
  logic mult = 0, pg_n = 1, pd_n = 1, cstp_n = 1, pstp_n = 1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic osc, external_test_clock, hiz, b66, swm, slow, vhub, spr, usb, display_48m_out;
  logic [1:0] fsel;
  logic [2:0] cpu_en, pcif_en, i66_en;
  logic [6:0] pci_en;
  int mismatches = 0, tests_run = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  cocs_smbus_if smb_if();
  cocs_host cocs_host_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
    .smb(smb_if), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  cocs_device cocs_device_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
    .smb(smb_if), .mode_select_mid_i(mid), .mode_select_tristate_i(tri_s),
    .freq_select_hi_i(fhi), .freq_select_lo_i(flo), .swing_multiplier_select_i(mult),
    .power_good_strobe_n_i(pg_n), .power_down_n_i(pd_n), .cpu_stop_n_i(cstp_n),
    .pci_stop_n_i(pstp_n), .osc_run_o(osc), .use_test_clock_o(external_test_clock), .outputs_hiz_o(hiz),
    .cpu_freq_sel_o(fsel), .buffered_66_mode_o(b66), .swing_mult_o(swm), .slow_vco_o(slow),
    .cpu_en_o(cpu_en), .pci_en_o(pci_en), .pci_free_en_o(pcif_en), .internal_66_en_o(i66_en),
    .usb_en_o(usb), .display_48m_en_o(display_48m_out), .video_hub_sel_o(vhub), .spread_en_o(spr));
  cocs_properties cocs_properties_inst (.smb_clk(smb_if.smb_clk), .nrst_i(nrst_i),
    .host_sda_oe(smb_if.host_sda_oe), .dev_sda_oe(smb_if.dev_sda_oe), .sda(smb_if.sda));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic do_reset;
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
  endtask
  // selects settle first, then power good strobes them in
  task automatic strap(input logic [4:0] s);
    @(posedge core_clk_i);
    {mid, tri_s, fhi, flo, mult} <= s;
    repeat (2) @(posedge core_clk_i);
    pg_n <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    pg_n <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 12; i++) begin
      do_reset();
      strap({i >= 8, i[2] && i < 8, i[1], i[0], i[0]});
      for (int p = 0; p < 2; p++) begin
        check(hiz, i == 8 || i > 9);
        check(external_test_clock, i == 9);
        check(slow, i == 9);
        check(swm, i[0]);
        if (i < 8) check({b66, fsel}, i[2:0]);
        if (i == 9) check(fsel, 2'h2);
        strap({i < 8, !i[2], !i[1], !i[0], !i[0]});
      end
    end
  endtask
  task automatic t_gate;
    check({osc, cpu_en, pci_en, pcif_en, i66_en, usb, display_48m_out, vhub, spr}, 21'h1FFFFC);
    pd_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    check({osc, pci_en, pcif_en, i66_en, usb, display_48m_out}, 0);
    pd_n   <= 1'b1;
    cstp_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    check({cpu_en, pci_en}, 10'h07F);
    cstp_n <= 1'b1;
    pstp_n <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    check({cpu_en, pci_en, pcif_en}, 13'h1C07);
    pstp_n <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic t_refuse;
    logic [7:0] r;
    reg_wr(4'h5, 8'h00);
    reg_rd(4'h6, r);
    check(r[0], 0);
    reg_wr(4'h5, 8'h06);
    reg_rd(4'h6, r);
    check(r[0], 0);
  endtask
  // one block write; wire bytes compared as they pass, then busy polled
  task automatic send(input logic [7:0] n, input logic [39:0] d);
    logic [7:0] exp [$];
    logic [7:0] b, r;
    int k;
    exp = {8'hD2, 8'h00, n};
    for (k = 0; k < 5; k++) reg_wr(k[3:0], d[39 - 8 * k -: 8]);
    for (k = 0; k < n; k++) exp.push_back(d[39 - 8 * k -: 8]);
    fork
      begin
        reg_wr(4'h5, n);
        reg_rd(4'h6, r);
        check(r[0], 1);
      end
      begin
        k = 0;
        do begin
          @(posedge smb_if.smb_clk);
          k++;
        end while (smb_if.sda !== 1'b0 && k < 200);
        check(k < 200, 1);
        foreach (exp[j]) begin
          for (int q = 0; q < 8; q++) begin
            @(posedge smb_if.smb_clk);
            b = {b[6:0], smb_if.sda};
          end
          check(b, exp[j]);
          @(posedge smb_if.smb_clk);
          check(smb_if.dev_sda_oe, 1);
        end
      end
    join
    k = 0;
    do begin
      reg_rd(4'h6, r);
      k++;
    end while (r[0] !== 1'b0 && k < 3000);
    check(k < 3000, 1);
    repeat (200) @(posedge core_clk_i);
  endtask
  task automatic t_frames;
    send(8'h05, 40'hA0_05_2A_45_10);
    check({spr, vhub, cpu_en, pci_en, pcif_en, usb, display_48m_out, i66_en}, 20'hEAAB2);
    // count of one at the low boundary: later bytes must stay as they were
    send(8'h01, 40'h80_02_55_FF_FF);
    check({spr, vhub, cpu_en, pci_en, pcif_en, usb, display_48m_out, i66_en}, 20'hAAAB2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge core_clk_i);
    mismatches++;
    conclude();
  end
  initial begin
    t_modes();
    do_reset();
    strap(5'h00);
    t_gate();
    t_refuse();
    t_frames();
    conclude();
  end
endmodule
